// >>> rtl/dual_timer_counter.sv
`timescale 1ns/1ps
`include "timer_counter_regs.svh"
module dual_timer_counter
    import timer_counter_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire sfr_req_t   sfrReq,
    output logic [7:0]      sfrRdata,
    output logic            sfrHit,
    input  wire logic       vectorTimer0,
    input  wire logic       vectorTimer1,
    input  wire logic       vectorIrq0,
    input  wire logic       vectorIrq1,
    input  wire logic       extIrqPin0_n,
    input  wire logic       extIrqPin1_n,
    input  wire logic       countInputPin0,
    input  wire logic       countInputPin1,
    output logic [7:0]      timerControlReg,
    output logic            timer1OverflowPulse
);
    logic       rstMeta_q, rstSync_q, rstInt_n;
    logic [3:0] phase_q;
    logic       machineTick;
    logic [7:0] ctrl_q, modeReg_q;
    logic [7:0] low_q [2];
    logic [7:0] high_q [2];
    logic [3:0] pinMeta_q, pinSync_q;
    logic [1:0] cntSample_q, irqSample_q;
    logic [1:0] lowInc, highInc, lowOvf, highOvf, ovfEvent;
    logic [1:0] runBit, pinFall, extLevel;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta_q <= 1'b0;
            rstSync_q <= 1'b0;
        end else begin
            rstMeta_q <= 1'b1;
            rstSync_q <= rstMeta_q;
        end
    end
    assign rstInt_n = rstSync_q;

    // Machine cycle divider; every slower rate is this one-cycle enable.
    always_ff @(posedge clk or negedge rstInt_n) begin
        if (!rstInt_n) begin
            phase_q <= 4'h0;
        end else if (phase_q == `MACHINE_CLOCKS - 4'h1) begin
            phase_q <= 4'h0;
        end else begin
            phase_q <= phase_q + 4'h1;
        end
    end
    assign machineTick = (phase_q == `MACHINE_CLOCKS - 4'h1);

    // Pins: [0] irq0, [1] irq1, [2] count0, [3] count1.
    always_ff @(posedge clk or negedge rstInt_n) begin
        if (!rstInt_n) begin
            pinMeta_q <= 4'hF;
            pinSync_q <= 4'hF;
        end else begin
            pinMeta_q <= {countInputPin1, countInputPin0,
                          extIrqPin1_n, extIrqPin0_n};
            pinSync_q <= pinMeta_q;
        end
    end

    // Per-cycle sampling so a fall needs a high then a low sample.
    always_ff @(posedge clk or negedge rstInt_n) begin
        if (!rstInt_n) begin
            cntSample_q <= 2'h3;
            irqSample_q <= 2'h3;
        end else if (machineTick) begin
            cntSample_q <= pinSync_q[3:2];
            irqSample_q <= pinSync_q[1:0];
        end
    end

    assign runBit = {ctrl_q[`BIT_T1_RUN], ctrl_q[`BIT_T0_RUN]};

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gTimer
            mode_nibble_t cfg;
            logic enable, pulse;
            logic incLow, incHigh, ovfLow, ovfHigh;
            assign cfg = mode_nibble_t'(modeReg_q[g*4 +: 4]);
            assign pinFall[g] = cntSample_q[g] & ~pinSync_q[2+g];
            assign extLevel[g] = pinSync_q[g];
            // Gate qualifies the run bit with the interrupt pin level.
            assign enable = runBit[g] & (~cfg.gate | extLevel[g]);
            assign pulse = machineTick & enable &
                           (cfg.counterSel ? pinFall[g] : 1'b1);
            // Local results keep each vector bit under a single driver.
            always_comb begin
                incLow  = 1'b0;
                incHigh = 1'b0;
                ovfLow  = 1'b0;
                ovfHigh = 1'b0;
                case (cfg.mode)
                    MODE_13BIT: begin
                        incLow  = pulse;
                        incHigh = pulse &
                            (low_q[g][4:0] == 5'(`PRESCALE_MAX));
                        ovfHigh = incHigh & (high_q[g] == 8'hFF);
                    end
                    MODE_16BIT: begin
                        incLow  = pulse;
                        incHigh = pulse & (low_q[g] == 8'hFF);
                        ovfHigh = incHigh & (high_q[g] == 8'hFF);
                    end
                    MODE_RELOAD: begin
                        incLow = pulse;
                        ovfLow = pulse & (low_q[g] == 8'hFF);
                    end
                    MODE_SPLIT: begin
                        // Timer 1 in this mode holds, as if stopped.
                        if (g == 0) begin
                            incLow = pulse;
                            ovfLow = pulse & (low_q[g] == 8'hFF);
                        end else begin
                            incLow = 1'b0;
                        end
                    end
                    default: begin
                        incLow = 1'b0;
                    end
                endcase
            end
            assign lowInc[g]  = incLow;
            assign highInc[g] = incHigh;
            assign lowOvf[g]  = ovfLow;
            assign highOvf[g] = ovfHigh;
            // Register write wins over any increment or reload.
            always_ff @(posedge clk or negedge rstInt_n) begin
                if (!rstInt_n) begin
                    low_q[g] <= `COUNT_RESET;
                end else if (sfrReq.wrEn &&
                             sfrReq.addr == `ADDR_T0_LOW + 8'(g)) begin
                    low_q[g] <= sfrReq.wdata;
                end else if (lowOvf[g] && cfg.mode == MODE_RELOAD) begin
                    low_q[g] <= high_q[g];
                end else if (lowInc[g]) begin
                    low_q[g] <= low_q[g] + 8'h01;
                end
            end
        end
    endgenerate

    // Split high byte: machine cycles only, timer 1 run bit.
    logic splitMode, splitHighInc;
    assign splitMode = (modeReg_q[1:0] == 2'b11);
    assign splitHighInc = splitMode & machineTick & runBit[1];

    always_ff @(posedge clk or negedge rstInt_n) begin
        if (!rstInt_n) begin
            high_q[0] <= `COUNT_RESET;
        end else if (sfrReq.wrEn && sfrReq.addr == `ADDR_T0_HIGH) begin
            high_q[0] <= sfrReq.wdata;
        end else if (highInc[0] || splitHighInc) begin
            high_q[0] <= high_q[0] + 8'h01;
        end
    end

    always_ff @(posedge clk or negedge rstInt_n) begin
        if (!rstInt_n) begin
            high_q[1] <= `COUNT_RESET;
        end else if (sfrReq.wrEn && sfrReq.addr == `ADDR_T1_HIGH) begin
            high_q[1] <= sfrReq.wdata;
        end else if (highInc[1]) begin
            high_q[1] <= high_q[1] + 8'h01;
        end
    end

    // Timer 1's flag follows the split high byte while timer 0 is split.
    assign ovfEvent[0] = highOvf[0] | lowOvf[0];
    assign ovfEvent[1] = splitMode ?
        (splitHighInc & (high_q[0] == 8'hFF)) :
        (highOvf[1] | lowOvf[1]);
    assign timer1OverflowPulse = ovfEvent[1];

    always_ff @(posedge clk or negedge rstInt_n) begin
        if (!rstInt_n) begin
            modeReg_q <= `MODE_RESET;
        end else if (sfrReq.wrEn && sfrReq.addr == `ADDR_MODE) begin
            modeReg_q <= sfrReq.wdata;
        end
    end

    // Control register: software data first, hardware sets last so set wins.
    logic [7:0] ctrlWr;
    logic [1:0] irqFall, irqSet;
    always_comb begin
        ctrlWr = ctrl_q;
        if (sfrReq.wrEn && sfrReq.addr == `ADDR_CONTROL) begin
            ctrlWr = sfrReq.wdata;
        end else if (sfrReq.bitWrEn && sfrReq.addr == `ADDR_CONTROL) begin
            ctrlWr[sfrReq.bitSel] = sfrReq.bitVal;
        end
    end
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            irqFall[i] = irqSample_q[i] & ~pinSync_q[i] & machineTick;
            irqSet[i] = ctrl_q[2*i] ? irqFall[i] :
                        (~pinSync_q[i] & machineTick);
        end
    end

    always_ff @(posedge clk or negedge rstInt_n) begin
        if (!rstInt_n) begin
            ctrl_q <= `CONTROL_RESET;
        end else begin
            ctrl_q <= ctrlWr;
            if (vectorTimer1) ctrl_q[`BIT_T1_OVF] <= 1'b0;
            if (vectorTimer0) ctrl_q[`BIT_T0_OVF] <= 1'b0;
            if (vectorIrq1 && ctrl_q[`BIT_IRQ1_EDGE])
                ctrl_q[`BIT_IRQ1_FLAG] <= 1'b0;
            if (vectorIrq0 && ctrl_q[`BIT_IRQ0_EDGE])
                ctrl_q[`BIT_IRQ0_FLAG] <= 1'b0;
            if (!ctrl_q[`BIT_IRQ1_EDGE] && pinSync_q[1] && machineTick)
                ctrl_q[`BIT_IRQ1_FLAG] <= 1'b0;
            if (!ctrl_q[`BIT_IRQ0_EDGE] && pinSync_q[0] && machineTick)
                ctrl_q[`BIT_IRQ0_FLAG] <= 1'b0;
            if (ovfEvent[1]) ctrl_q[`BIT_T1_OVF] <= 1'b1;
            if (ovfEvent[0]) ctrl_q[`BIT_T0_OVF] <= 1'b1;
            if (irqSet[1]) ctrl_q[`BIT_IRQ1_FLAG] <= 1'b1;
            if (irqSet[0]) ctrl_q[`BIT_IRQ0_FLAG] <= 1'b1;
        end
    end
    assign timerControlReg = ctrl_q;

    // Read data is registered; unmapped addresses return zero and no hit.
    always_ff @(posedge clk or negedge rstInt_n) begin
        if (!rstInt_n) begin
            sfrRdata <= 8'h00;
            sfrHit   <= 1'b0;
        end else begin
            sfrHit <= sfrReq.rdEn;
            case (sfrReq.addr)
                `ADDR_CONTROL: sfrRdata <= ctrl_q;
                `ADDR_MODE:    sfrRdata <= modeReg_q;
                `ADDR_T0_LOW:  sfrRdata <= low_q[0];
                `ADDR_T1_LOW:  sfrRdata <= low_q[1];
                `ADDR_T0_HIGH: sfrRdata <= high_q[0];
                `ADDR_T1_HIGH: sfrRdata <= high_q[1];
                default: begin
                    sfrRdata <= 8'h00;
                    sfrHit   <= 1'b0;
                end
            endcase
        end
    end

    property p_tick_period;
        @(posedge clk) disable iff (!rstInt_n)
        machineTick |=> !machineTick [*8] ##1 !machineTick [*3]
        ##1 machineTick;
    endproperty
    a_tick_period: assert property (p_tick_period)
        else $error("machine tick period not 12");

    property p_stop_hold;
        @(posedge clk) disable iff (!rstInt_n)
        (!runBit[0] && !(sfrReq.wrEn && sfrReq.addr == `ADDR_T0_LOW))
        |=> $stable(low_q[0]);
    endproperty
    a_stop_hold: assert property (p_stop_hold)
        else $error("stopped timer 0 low byte moved");

    property p_gate_block;
        @(posedge clk) disable iff (!rstInt_n)
        (modeReg_q[3] && !pinSync_q[0]) |-> !lowInc[0];
    endproperty
    a_gate_block: assert property (p_gate_block)
        else $error("gated timer 0 counted while pin low");

    property p_t1_mode3_hold;
        @(posedge clk) disable iff (!rstInt_n)
        (modeReg_q[5:4] == 2'b11 && !sfrReq.wrEn) |=>
        $stable(low_q[1]) && $stable(high_q[1]);
    endproperty
    a_t1_mode3_hold: assert property (p_t1_mode3_hold)
        else $error("timer 1 in mode 3 changed count");

    property p_reload;
        @(posedge clk) disable iff (!rstInt_n)
        (lowOvf[0] && modeReg_q[1:0] == 2'b10 && !sfrReq.wrEn) |=>
        low_q[0] == high_q[0] && $stable(high_q[0]);
    endproperty
    a_reload: assert property (p_reload)
        else $error("auto-reload wrong");

    property p_t0_flag;
        @(posedge clk) disable iff (!rstInt_n)
        ovfEvent[0] |=> ctrl_q[`BIT_T0_OVF];
    endproperty
    a_t0_flag: assert property (p_t0_flag)
        else $error("timer 0 flag not set");

    property p_t1_flag;
        @(posedge clk) disable iff (!rstInt_n)
        ovfEvent[1] |=> ctrl_q[`BIT_T1_OVF];
    endproperty
    a_t1_flag: assert property (p_t1_flag)
        else $error("timer 1 flag not set");

    property p_write_wins;
        @(posedge clk) disable iff (!rstInt_n)
        (sfrReq.wrEn && sfrReq.addr == `ADDR_T0_HIGH) |=>
        high_q[0] == $past(sfrReq.wdata);
    endproperty
    a_write_wins: assert property (p_write_wins)
        else $error("count write lost");

    property p_level_irq;
        @(posedge clk) disable iff (!rstInt_n)
        (!ctrl_q[`BIT_IRQ0_EDGE] && !pinSync_q[0] && machineTick) |=>
        ctrl_q[`BIT_IRQ0_FLAG];
    endproperty
    a_level_irq: assert property (p_level_irq)
        else $error("level irq0 flag not set");

    property p_t1_stop_hold;
        @(posedge clk) disable iff (!rstInt_n)
        (!runBit[1] && !(sfrReq.wrEn && sfrReq.addr == `ADDR_T1_LOW))
        |=> $stable(low_q[1]);
    endproperty
    a_t1_stop_hold: assert property (p_t1_stop_hold)
        else $error("stopped timer 1 low byte moved");

    property p_edge_vector_clear;
        @(posedge clk) disable iff (!rstInt_n)
        (vectorIrq1 && ctrl_q[`BIT_IRQ1_EDGE] && !irqSet[1] &&
         !(sfrReq.addr == `ADDR_CONTROL &&
           (sfrReq.wrEn || sfrReq.bitWrEn)))
        |=> !ctrl_q[`BIT_IRQ1_FLAG];
    endproperty
    a_edge_vector_clear: assert property (p_edge_vector_clear)
        else $error("edge irq1 flag not cleared by vector");

    property p_level_vector_keep;
        @(posedge clk) disable iff (!rstInt_n)
        (vectorIrq0 && !ctrl_q[`BIT_IRQ0_EDGE] &&
         ctrl_q[`BIT_IRQ0_FLAG] && !pinSync_q[0] &&
         !(sfrReq.addr == `ADDR_CONTROL &&
           (sfrReq.wrEn || sfrReq.bitWrEn)))
        |=> ctrl_q[`BIT_IRQ0_FLAG];
    endproperty
    a_level_vector_keep: assert property (p_level_vector_keep)
        else $error("level irq0 flag cleared by vector");

    c_t0_ovf: cover property (@(posedge clk) ovfEvent[0]);
    c_split: cover property (@(posedge clk) splitHighInc);
    c_reload: cover property (@(posedge clk) lowOvf[0]);
    c_edge: cover property (@(posedge clk) irqFall[1]);
endmodule

// >>> rtl/timer_counter_pkg.sv
package timer_counter_pkg;
    typedef enum logic [1:0] {
        MODE_13BIT,
        MODE_16BIT,
        MODE_RELOAD,
        MODE_SPLIT
    } timer_mode_t;
    typedef struct packed {
        logic        gate;
        logic        counterSel;
        timer_mode_t mode;
    } mode_nibble_t;
    typedef struct packed {
        logic       wrEn;
        logic       rdEn;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       bitWrEn;
        logic [2:0] bitSel;
        logic       bitVal;
    } sfr_req_t;
endpackage

// >>> rtl/timer_counter_regs.svh
// Function
// - Gate set: count only while pin high and run.
// - Gate clear: count whenever run bit set.
// - Counter select picks external pin or machine cycles.
// - Mode 00: 5-bit prescaler feeding 8-bit high byte.
// - Mode 01: full 16-bit cascaded counter.
// - Mode 10: low byte reloads from high on overflow.
// - Timer 0 mode 11 splits into two 8-bit counters.
// - Timer 1 mode 11 holds its count.
// - Timer 1 overflow sets flag; vector clears it.
// - Timer 0 overflow sets flag; vector clears it.
// - Timer 1 run bit under software control.
// - Timer 0 run bit under software control.
// - External flags set by falling edge or low level.
// - Vector clears external flag only when edge-triggered.
// - Trigger bit set selects edge, clear selects level.
// - Control register at 88H, resets 00H, bit-addressable.
// - Timer 0 high at 8CH, low at 8AH.
// - Timer 1 high at 8DH, low at 8BH.
// - Both timers share identical mode logic except in mode 11.
// - Timer mode counts once per 12-clock machine cycle.
// - Counter samples pin per cycle, counts high-to-low.
// - Auto-reload leaves the high byte unchanged.
`ifndef TIMER_COUNTER_REGS_SVH
`define TIMER_COUNTER_REGS_SVH
`define ADDR_CONTROL     8'h88
`define ADDR_MODE        8'h89
`define ADDR_T0_LOW      8'h8A
`define ADDR_T1_LOW      8'h8B
`define ADDR_T0_HIGH     8'h8C
`define ADDR_T1_HIGH     8'h8D
`define CONTROL_RESET    8'h00
`define MODE_RESET       8'h00
`define COUNT_RESET      8'h00
`define BIT_T1_OVF       3'h7
`define BIT_T1_RUN       3'h6
`define BIT_T0_OVF       3'h5
`define BIT_T0_RUN       3'h4
`define BIT_IRQ1_FLAG    3'h3
`define BIT_IRQ1_EDGE    3'h2
`define BIT_IRQ0_FLAG    3'h1
`define BIT_IRQ0_EDGE    3'h0
`define MACHINE_CLOCKS   4'hC
`define PRESCALE_MAX     8'h1F
`endif

// >>> test/dual_timer_counter_t0_t1_tb_top.sv
`timescale 1ns/1ps
`include "timer_counter_regs.svh"
`define CHECK_EQ(got, exp) begin \
    nChecks++; \
    if ((got) !== (exp)) begin \
        nErrors++; \
        $display("[FAIL] %0t got %h exp %h", $time, got, exp); \
    end \
end
module dual_timer_counter_t0_t1_tb_top;
    import timer_counter_pkg::*;
    logic       clk;
    logic       rst_n;
    sfr_req_t   sfrReq;
    logic [7:0] sfrRdata;
    logic       sfrHit;
    logic [3:0] vec;
    logic       irqPin0_n;
    logic       irqPin1_n;
    logic       countPin0;
    logic       countPin1;
    logic [7:0] timerControlReg;
    logic       ovfPulse;
    int         nErrors;
    int         nChecks;
    int         nOvf1 = 0;

    dual_timer_counter i_dual_timer_counter (
        .clk                 (clk),
        .rst_n               (rst_n),
        .sfrReq              (sfrReq),
        .sfrRdata            (sfrRdata),
        .sfrHit              (sfrHit),
        .vectorTimer0        (vec[0]),
        .vectorTimer1        (vec[1]),
        .vectorIrq0          (vec[2]),
        .vectorIrq1          (vec[3]),
        .extIrqPin0_n        (irqPin0_n),
        .extIrqPin1_n        (irqPin1_n),
        .countInputPin0      (countPin0),
        .countInputPin1      (countPin1),
        .timerControlReg     (timerControlReg),
        .timer1OverflowPulse (ovfPulse)
    );

    pin_source_model i_pin_source_model (
        .clk       (clk),
        .irqPin0_n (irqPin0_n),
        .irqPin1_n (irqPin1_n),
        .countPin0 (countPin0),
        .countPin1 (countPin1)
    );

    initial clk = 1'b0;
    always #20 clk = ~clk;

    // Mid-cycle sampling sees the one-cycle overflow pulse settled.
    always @(negedge clk) begin
        if (ovfPulse === 1'b1) nOvf1 <= nOvf1 + 1;
    end

    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfrReq.wrEn  <= 1'b1;
        sfrReq.addr  <= a;
        sfrReq.wdata <= d;
        @(posedge clk);
        sfrReq.wrEn  <= 1'b0;
    endtask

    task automatic write_bit(input logic [2:0] b, input logic v);
        @(posedge clk);
        sfrReq.bitWrEn <= 1'b1;
        sfrReq.addr    <= `ADDR_CONTROL;
        sfrReq.bitSel  <= b;
        sfrReq.bitVal  <= v;
        @(posedge clk);
        sfrReq.bitWrEn <= 1'b0;
    endtask

    task automatic read_reg(input logic [7:0] a, input logic [7:0] e,
                            input logic hit);
        @(posedge clk);
        sfrReq.rdEn <= 1'b1;
        sfrReq.addr <= a;
        @(posedge clk);
        sfrReq.rdEn <= 1'b0;
        #1;
        `CHECK_EQ(sfrRdata, e)
        `CHECK_EQ(sfrHit, hit)
    endtask

    task automatic wait_ctrl(input int b, input logic v, input int lim);
        int i;
        for (i = 0; i < lim; i++) begin
            @(posedge clk);
            #1;
            if (timerControlReg[b] === v) break;
        end
        `CHECK_EQ(timerControlReg[b], v)
    endtask

    task automatic vector(input int k);
        @(posedge clk);
        vec[k] <= 1'b1;
        @(posedge clk);
        vec[k] <= 1'b0;
    endtask

    task automatic end_test(input string name);
        $display("test %s finished at %0t", name, $time);
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", nChecks, nErrors);
        if (nErrors == 0 && nChecks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Stop a hung handshake long after every test should have ended.
    initial begin
        #2000000;
        nErrors++;
        $display("[FAIL] %0t watchdog expired", $time);
        wrap_up();
    end

    initial begin
        nErrors = 0;
        nChecks = 0;
        rst_n   = 1'b0;
        sfrReq  = '0;
        vec     = '0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        read_reg(`ADDR_CONTROL, 8'h00, 1'b1);
        read_reg(`ADDR_MODE, 8'h00, 1'b1);
        read_reg(8'h90, 8'h00, 1'b0);
        write_reg(`ADDR_T0_LOW, 8'h12);
        write_reg(`ADDR_T1_LOW, 8'h34);
        write_reg(`ADDR_T0_HIGH, 8'h56);
        write_reg(`ADDR_T1_HIGH, 8'h78);
        read_reg(`ADDR_T0_LOW, 8'h12, 1'b1);
        read_reg(`ADDR_T1_LOW, 8'h34, 1'b1);
        read_reg(`ADDR_T0_HIGH, 8'h56, 1'b1);
        read_reg(`ADDR_T1_HIGH, 8'h78, 1'b1);
        end_test("map");
        write_reg(`ADDR_MODE, 8'h01);
        write_reg(`ADDR_T0_HIGH, 8'hFF);
        write_reg(`ADDR_T0_LOW, 8'hFE);
        write_bit(`BIT_T0_RUN, 1'b1);
        repeat (11) @(posedge clk);
        #1;
        `CHECK_EQ(timerControlReg[5], 1'b0)
        wait_ctrl(5, 1'b1, 30);
        write_bit(`BIT_T0_RUN, 1'b0);
        read_reg(`ADDR_T0_HIGH, 8'h00, 1'b1);
        read_reg(`ADDR_T0_LOW, 8'h00, 1'b1);
        vector(0);
        wait_ctrl(5, 1'b0, 4);
        end_test("wide");
        write_reg(`ADDR_MODE, 8'h00);
        write_reg(`ADDR_T1_HIGH, 8'hFF);
        write_reg(`ADDR_T1_LOW, 8'h1F);
        write_bit(`BIT_T1_RUN, 1'b1);
        wait_ctrl(7, 1'b1, 30);
        write_bit(`BIT_T1_RUN, 1'b0);
        read_reg(`ADDR_T1_HIGH, 8'h00, 1'b1);
        vector(1);
        wait_ctrl(7, 1'b0, 4);
        end_test("prescale");
        write_reg(`ADDR_MODE, 8'h02);
        write_reg(`ADDR_T0_HIGH, 8'hA0);
        write_reg(`ADDR_T0_LOW, 8'hFF);
        write_bit(`BIT_T0_RUN, 1'b1);
        wait_ctrl(5, 1'b1, 30);
        write_bit(`BIT_T0_RUN, 1'b0);
        read_reg(`ADDR_T0_HIGH, 8'hA0, 1'b1);
        read_reg(`ADDR_T0_LOW, 8'hA0, 1'b1);
        write_bit(`BIT_T0_OVF, 1'b0);
        end_test("reload");
        write_reg(`ADDR_MODE, 8'h09);
        write_reg(`ADDR_T0_HIGH, 8'hFF);
        write_reg(`ADDR_T0_LOW, 8'hFF);
        i_pin_source_model.set_irq0(1'b0);
        write_bit(`BIT_T0_RUN, 1'b1);
        repeat (60) @(posedge clk);
        #1;
        `CHECK_EQ(timerControlReg[5], 1'b0)
        i_pin_source_model.set_irq0(1'b1);
        wait_ctrl(5, 1'b1, 40);
        write_reg(`ADDR_MODE, 8'h01);
        write_reg(`ADDR_T0_LOW, 8'hFF);
        write_reg(`ADDR_T0_HIGH, 8'hFF);
        write_bit(`BIT_T0_OVF, 1'b0);
        i_pin_source_model.set_irq0(1'b0);
        wait_ctrl(5, 1'b1, 30);
        end_test("gate");
        write_reg(`ADDR_CONTROL, 8'h00);
        write_reg(`ADDR_MODE, 8'h05);
        write_reg(`ADDR_T0_HIGH, 8'h00);
        write_reg(`ADDR_T0_LOW, 8'h00);
        write_bit(`BIT_T0_RUN, 1'b1);
        i_pin_source_model.count_pulses(3);
        write_bit(`BIT_T0_RUN, 1'b0);
        read_reg(`ADDR_T0_LOW, 8'h03, 1'b1);
        end_test("counter");
        write_reg(`ADDR_CONTROL, 8'h00);
        write_reg(`ADDR_MODE, 8'h33);
        write_reg(`ADDR_T1_LOW, 8'h55);
        write_reg(`ADDR_T0_HIGH, 8'hFF);
        write_bit(`BIT_T1_RUN, 1'b1);
        wait_ctrl(7, 1'b1, 30);
        write_bit(`BIT_T1_RUN, 1'b0);
        read_reg(`ADDR_T0_HIGH, 8'h00, 1'b1);
        read_reg(`ADDR_T0_LOW, 8'h03, 1'b1);
        read_reg(`ADDR_T1_LOW, 8'h55, 1'b1);
        `CHECK_EQ(nOvf1, 2)
        end_test("split");
        write_reg(`ADDR_CONTROL, 8'h00);
        wait_ctrl(1, 1'b1, 40);
        vector(2);
        repeat (2) @(posedge clk);
        #1;
        `CHECK_EQ(timerControlReg[1], 1'b1)
        i_pin_source_model.set_irq0(1'b1);
        wait_ctrl(1, 1'b0, 40);
        write_bit(`BIT_IRQ1_EDGE, 1'b1);
        i_pin_source_model.pulse_irq1();
        wait_ctrl(3, 1'b1, 40);
        vector(3);
        wait_ctrl(3, 1'b0, 4);
        read_reg(`ADDR_CONTROL, 8'h04, 1'b1);
        end_test("external");
        wrap_up();
    end
endmodule

// >>> test/pin_source_model.sv
`timescale 1ns/1ps
module pin_source_model (
    input  wire logic clk,
    output logic      irqPin0_n,
    output logic      irqPin1_n,
    output logic      countPin0,
    output logic      countPin1
);
    initial begin
        irqPin0_n = 1'b1;
        irqPin1_n = 1'b1;
        countPin0 = 1'b1;
        countPin1 = 1'b1;
    end

    // Each level stands two machine cycles so one sample always sees it.
    task automatic count_pulses(input int n);
        repeat (n) begin
            @(posedge clk);
            countPin0 <= 1'b0;
            repeat (24) @(posedge clk);
            countPin0 <= 1'b1;
            repeat (24) @(posedge clk);
        end
    endtask

    // A level request is held or released by this source alone.
    task automatic set_irq0(input logic lvl);
        @(posedge clk);
        irqPin0_n <= lvl;
    endtask

    task automatic pulse_irq1;
        @(posedge clk);
        irqPin1_n <= 1'b0;
        repeat (24) @(posedge clk);
        irqPin1_n <= 1'b1;
    endtask
endmodule
